// ==== src/cpw_pkg.sv ====
// ----------------------------------------------------------------------------
// Shared constants for the three-phase complementary PWM block
// ----------------------------------------------------------------------------
package cpw_pkg;

	// ------------------------------------------------------------------------
	// Register byte addresses on the APB slave
	// ------------------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL          = 8'h00; // Control bits
	localparam logic [7:0] ADDR_STATUS        = 8'h04; // Status and sticky flag
	localparam logic [7:0] ADDR_UPPER_CMP     = 8'h08; // upper_limit_compare
	localparam logic [7:0] ADDR_PH1_CMP       = 8'h0C; // phase1_duty_compare
	localparam logic [7:0] ADDR_UPPER_BUF     = 8'h10; // upper_limit_buffer
	localparam logic [7:0] ADDR_PH1_BUF       = 8'h14; // phase1_duty_buffer
	localparam logic [7:0] ADDR_PH2_CMP       = 8'h18; // phase2_duty_compare
	localparam logic [7:0] ADDR_PH3_CMP       = 8'h1C; // phase3_duty_compare
	localparam logic [7:0] ADDR_PH2_BUF       = 8'h20; // phase2_duty_buffer
	localparam logic [7:0] ADDR_PH3_BUF       = 8'h24; // phase3_duty_buffer
	localparam logic [7:0] ADDR_PRI_CNT       = 8'h28; // primary_counter
	localparam logic [7:0] ADDR_SEC_CNT       = 8'h2C; // secondary_counter
	localparam logic [7:0] ADDR_DEAD          = 8'h30; // dead_time_value
	localparam logic [7:0] ADDR_HALF          = 8'h34; // half_cycle_value
	localparam logic [7:0] ADDR_HALF_BUF      = 8'h38; // half_cycle_buffer

	// ------------------------------------------------------------------------
	// Control register field positions
	// ------------------------------------------------------------------------
	localparam int CTRL_W          = 7;
	localparam int CTRL_START      = 0; // Counters run while set
	localparam int CTRL_NO_DEAD    = 1; // Drop the non-overlap gap
	localparam int CTRL_TOGGLE_EN  = 2; // Toggle output at every crest
	localparam int CTRL_POS_LEVEL  = 3; // positive_level_select, 1 = active high
	localparam int CTRL_INV_LEVEL  = 4; // inverse_level_select, 1 = active high
	localparam int CTRL_DIV4       = 5; // Counter clock is pclk / 4
	localparam int CTRL_IRQ_EN     = 6; // Crest match drives the request line

	// ------------------------------------------------------------------------
	// Status register field positions
	// ------------------------------------------------------------------------
	localparam int STAT_CREST      = 0; // Sticky crest match, write 1 to clear
	localparam int STAT_RUN        = 1; // Counters running
	localparam int STAT_UP_PRI     = 2; // Primary counter counting up
	localparam int STAT_UP_SEC     = 3; // Secondary counter counting up
	localparam int STAT_TOGGLE     = 4; // Current toggle output level

	// ------------------------------------------------------------------------
	// Reset values and counts
	// ------------------------------------------------------------------------
	localparam logic [15:0]       REG_RESET    = 16'h0000;
	localparam logic [CTRL_W-1:0] CTRL_RESET   = 7'h00;
	localparam logic              TOGGLE_INIT  = 1'b1;
	localparam logic [1:0]        DIV4_LAST    = 2'h3;  // Last count of the /4 divider

	// ------------------------------------------------------------------------
	// Run states, one-hot
	// ------------------------------------------------------------------------
	typedef enum logic [1:0] {
		CPW_IDLE = 2'b01,
		CPW_RUN  = 2'b10
	} cpw_state_e;

endpackage : cpw_pkg

// ==== src/cpw_prescale.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// Counter clock enable: every pclk or every fourth pclk
// ----------------------------------------------------------------------------
module cpw_prescale (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic run,      // Divider held cleared while stopped
	input  wire logic div4_sel, // Select the /4 rate
	output logic      tick      // One-cycle counter clock enable
);
	import cpw_pkg::*;

	// Whole state of the divider
	typedef struct packed {
		logic [1:0] cnt; // Divider phase
	} cpw_div_s;

	cpw_div_s s;      // Registered state
	cpw_div_s next_s; // Next state

	// ------------------------------------------------------------------------
	// Divider
	// ------------------------------------------------------------------------
	// Cleared while stopped so the first tick after start has a fixed phase
	always_comb begin
		next_s = s;
		if (!run) begin
			next_s.cnt = 2'h0;
		end else begin
			next_s.cnt = 2'(s.cnt + 2'h1);
		end
	end

	// Register the divider
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s.cnt <= 2'h0;
		end else begin
			s <= next_s;
		end
	end

	// Tick every cycle, or on the last of four
	assign tick = run && (!div4_sel || (s.cnt == DIV4_LAST));

endmodule : cpw_prescale
`default_nettype wire

// ==== src/cpw_top.sv ====
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module cpw_top (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             carrier_toggle_out,
	output logic             phase1_positive_out,
	output logic             phase1_inverse_out,
	output logic             phase2_positive_out,
	output logic             phase2_inverse_out,
	output logic             phase3_positive_out,
	output logic             phase3_inverse_out,
	output logic             crest_irq
);
	import cpw_pkg::*;

	// ------------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------------
	typedef struct packed {
		cpw_state_e        st;          // Run state
		logic [CTRL_W-1:0] ctrl;        // Control bits
		logic [15:0]       upper;       // upper_limit_compare
		logic [15:0]       upper_buf;   // upper_limit_buffer
		logic [2:0][15:0]  duty;        // Phase duty compares
		logic [2:0][15:0]  duty_buf;    // Phase duty buffers
		logic [2:0][15:0]  stage_duty;  // hidden_transfer_stage, one per phase
		logic [15:0]       stage_upper; // Hidden stage for the upper limit
		logic [15:0]       stage_half;  // Hidden stage for the half cycle
		logic              pend;        // Stage holds a set not yet applied
		logic [15:0]       half;        // half_cycle_value
		logic [15:0]       half_buf;    // half_cycle_buffer
		logic [15:0]       dead;        // dead_time_value
		logic [15:0]       cnt_pri;     // primary_counter
		logic [15:0]       cnt_sec;     // secondary_counter
		logic              up_pri;      // Primary direction, 1 = up
		logic              up_sec;      // Secondary direction, 1 = up
		logic              flag;        // Sticky crest match
		logic              tog;         // Toggle output level
		logic [2:0][1:0]   pins;        // Per phase {positive, inverse} pin levels
		logic [31:0]       rdata;       // Read data for the access phase
	} cpw_top_s;

	cpw_top_s s;      // Registered state
	cpw_top_s next_s; // Next state
	logic     tick;   // Counter clock enable
	logic     run;    // Counters running

	// ------------------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------------------
	// One counter step: turn at the limit in the current direction, then move
	function automatic logic [16:0] cpw_step(input logic [15:0] cnt, input logic up,
			input logic [15:0] top, input logic [15:0] bottom);
		logic nup;
		nup = up;
		if (up && (cnt == top)) begin
			nup = 1'b0;
		end else if (!up && (cnt == bottom)) begin
			nup = 1'b1;
		end
		return {nup, nup ? 16'(cnt + 16'h1) : 16'(cnt - 16'h1)};
	endfunction : cpw_step

	// Pin levels {positive, inverse} for one phase
	// Positive is on while the secondary count sits at or above the duty, inverse
	// while the primary count sits below it; the primary runs one dead time ahead,
	// so unless CTRL_NO_DEAD is set the two on-windows are apart by the dead time.
	function automatic logic [1:0] cpw_drive(input logic [15:0] d, input logic [15:0] pri,
			input logic [15:0] sec, input logic [15:0] upper, input logic [CTRL_W-1:0] c,
			input logic active);
		logic pos_on;
		logic inv_on;
		pos_on = 1'b0;
		inv_on = 1'b0;
		if (active) begin
			if (d == REG_RESET) begin
				pos_on = 1'b1;
			end else if (d >= upper) begin
				inv_on = 1'b1;
			end else begin
				pos_on = (sec >= d);
				// Without the gap the inverse is the exact complement
				inv_on = c[CTRL_NO_DEAD] ? !pos_on : (pri < d);
			end
		end
		// Level selects: 0 makes the on state a low pin
		return {c[CTRL_POS_LEVEL] ? pos_on : !pos_on,
			c[CTRL_INV_LEVEL] ? inv_on : !inv_on};
	endfunction : cpw_drive

	// Address decode, used by the error answer; the read path decodes with its own case
	function automatic logic cpw_mapped(input logic [7:0] a);
		return (a[1:0] == 2'h0) && (a <= ADDR_HALF_BUF);
	endfunction : cpw_mapped

	// ------------------------------------------------------------------------
	// Counter clock
	// ------------------------------------------------------------------------
	cpw_prescale u_prescale (
		.pclk     (pclk),
		.presetn  (presetn),
		.run      (run),
		.div4_sel (s.ctrl[CTRL_DIV4]),
		.tick     (tick)
	);

	assign run = (s.st == CPW_RUN);

	// ------------------------------------------------------------------------
	// Next-state logic: register writes, then the counting engine
	// ------------------------------------------------------------------------
	// Hardware events are applied after software writes so a crest set of the flag beats a clear
	always_comb begin
		logic        wr;
		logic        crest;
		logic        trough;
		logic [16:0] stp;
		logic [15:0] wd;
		next_s = s;
		wr     = psel && penable && pwrite;
		crest  = 1'b0;
		trough = 1'b0;
		stp    = 17'h0;
		wd     = pwdata[15:0];

		// Register writes; compares and counters are locked while running
		if (wr) begin
			case (paddr)
				ADDR_CTRL: begin
					next_s.ctrl = pwdata[CTRL_W-1:0];
				end
				ADDR_STATUS: begin
					if (pwdata[STAT_CREST]) begin
						next_s.flag = 1'b0;
					end
				end
				ADDR_UPPER_CMP: begin
					if (!run) begin
						next_s.upper = wd;
					end
				end
				ADDR_PH1_CMP: begin
					if (!run) begin
						next_s.duty[0] = wd;
					end
				end
				ADDR_PH2_CMP: begin
					if (!run) begin
						next_s.duty[1] = wd;
					end
				end
				ADDR_PH3_CMP: begin
					if (!run) begin
						next_s.duty[2] = wd;
					end
				end
				ADDR_UPPER_BUF: begin
					next_s.upper_buf = wd;
				end
				ADDR_PH1_BUF: begin
					next_s.duty_buf[0] = wd;
				end
				ADDR_PH2_BUF: begin
					next_s.duty_buf[1] = wd;
				end
				ADDR_PH3_BUF: begin
					next_s.duty_buf[2] = wd;
					// Writing phase three while running closes the set and moves every buffer
					// into the hidden stage, which software cannot reach
					if (run) begin
						next_s.stage_duty  = {wd, s.duty_buf[1], s.duty_buf[0]};
						next_s.stage_upper = s.upper_buf;
						next_s.stage_half  = s.half_buf;
						next_s.pend        = 1'b1;
					end
				end
				ADDR_PRI_CNT: begin
					if (!run) begin
						next_s.cnt_pri = wd;
					end
				end
				ADDR_SEC_CNT: begin
					if (!run) begin
						next_s.cnt_sec = wd;
					end
				end
				ADDR_DEAD: begin
					next_s.dead = wd;
				end
				ADDR_HALF: begin
					if (!run) begin
						next_s.half = wd;
					end
				end
				ADDR_HALF_BUF: begin
					next_s.half_buf = wd;
				end
				default: begin
					// Unmapped: nothing stored, error answered on pslverr
				end
			endcase
		end

		// Counting engine
		case (s.st)
			CPW_IDLE: begin
				if (next_s.ctrl[CTRL_START]) begin
					// Both counters loaded and released in the same cycle
					next_s.st      = CPW_RUN;
					next_s.cnt_pri = s.dead;
					next_s.cnt_sec = REG_RESET;
					next_s.up_pri  = 1'b1;
					next_s.up_sec  = 1'b1;
					next_s.tog     = TOGGLE_INIT;
					next_s.pend    = 1'b0;
				end
			end
			CPW_RUN: begin
				if (!next_s.ctrl[CTRL_START]) begin
					next_s.st = CPW_IDLE;
				end else if (tick) begin
					// Crest: primary meets the upper limit counting up
					crest  = s.up_pri && (s.cnt_pri == s.upper);
					// Trough: secondary meets zero counting down
					trough = !s.up_sec && (s.cnt_sec == REG_RESET);
					stp = cpw_step(s.cnt_pri, s.up_pri, s.upper, s.dead);
					next_s.up_pri  = stp[16];
					next_s.cnt_pri = stp[15:0];
					stp = cpw_step(s.cnt_sec, s.up_sec, s.half, REG_RESET);
					next_s.up_sec  = stp[16];
					next_s.cnt_sec = stp[15:0];
					if (crest) begin
						next_s.flag = 1'b1;
						if (s.ctrl[CTRL_TOGGLE_EN]) begin
							next_s.tog = !s.tog;
						end
					end
					// A half-written set stays in the buffers until the next
					// phase three write, so it never lands mid-period
					if ((crest || trough) && s.pend) begin
						next_s.duty  = s.stage_duty;
						next_s.upper = s.stage_upper;
						next_s.half  = s.stage_half;
						next_s.pend  = 1'b0;
					end
				end
			end
			default: begin
				next_s.st = CPW_IDLE;
			end
		endcase

		// Output pins for the three phases, off while stopped
		for (int i = 0; i < 3; i++) begin
			next_s.pins[i] = cpw_drive(s.duty[i], s.cnt_pri, s.cnt_sec, s.upper, s.ctrl, run);
		end

		// Read data captured in the setup cycle, shown in the access cycle
		if (psel && !penable) begin
			next_s.rdata = 32'h0;
			case (paddr)
				ADDR_CTRL:      next_s.rdata[CTRL_W-1:0] = s.ctrl;
				ADDR_STATUS:    next_s.rdata[4:0] = {s.tog, s.up_sec, s.up_pri, run, s.flag};
				ADDR_UPPER_CMP: next_s.rdata[15:0] = s.upper;
				ADDR_PH1_CMP:   next_s.rdata[15:0] = s.duty[0];
				ADDR_UPPER_BUF: next_s.rdata[15:0] = s.upper_buf;
				ADDR_PH1_BUF:   next_s.rdata[15:0] = s.duty_buf[0];
				ADDR_PH2_CMP:   next_s.rdata[15:0] = s.duty[1];
				ADDR_PH3_CMP:   next_s.rdata[15:0] = s.duty[2];
				ADDR_PH2_BUF:   next_s.rdata[15:0] = s.duty_buf[1];
				ADDR_PH3_BUF:   next_s.rdata[15:0] = s.duty_buf[2];
				ADDR_PRI_CNT:   next_s.rdata[15:0] = s.cnt_pri;
				ADDR_SEC_CNT:   next_s.rdata[15:0] = s.cnt_sec;
				ADDR_DEAD:      next_s.rdata[15:0] = s.dead;
				ADDR_HALF:      next_s.rdata[15:0] = s.half;
				ADDR_HALF_BUF:  next_s.rdata[15:0] = s.half_buf;
				default:        next_s.rdata = 32'h0;
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------------
	// Pins reset to the off level of active-low outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s.st          <= CPW_IDLE;
			s.ctrl        <= CTRL_RESET;
			s.upper       <= REG_RESET;
			s.upper_buf   <= REG_RESET;
			s.duty        <= {3{REG_RESET}};
			s.duty_buf    <= {3{REG_RESET}};
			s.stage_duty  <= {3{REG_RESET}};
			s.stage_upper <= REG_RESET;
			s.stage_half  <= REG_RESET;
			s.pend        <= 1'b0;
			s.half        <= REG_RESET;
			s.half_buf    <= REG_RESET;
			s.dead        <= REG_RESET;
			s.cnt_pri     <= REG_RESET;
			s.cnt_sec     <= REG_RESET;
			s.up_pri      <= 1'b1;
			s.up_sec      <= 1'b1;
			s.flag        <= 1'b0;
			s.tog         <= TOGGLE_INIT;
			s.pins        <= {3{2'b11}};
			s.rdata       <= 32'h0;
		end else begin
			s <= next_s;
		end
	end

	// ------------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------------
	assign prdata              = s.rdata;
	assign pready              = 1'b1; // Zero wait states
	assign pslverr             = psel && penable && !cpw_mapped(paddr);
	assign carrier_toggle_out  = s.tog;
	assign phase1_positive_out = s.pins[0][1];
	assign phase1_inverse_out  = s.pins[0][0];
	assign phase2_positive_out = s.pins[1][1];
	assign phase2_inverse_out  = s.pins[1][0];
	assign phase3_positive_out = s.pins[2][1];
	assign phase3_inverse_out  = s.pins[2][0];
	assign crest_irq           = s.flag && s.ctrl[CTRL_IRQ_EN];

endmodule : cpw_top
`default_nettype wire

// ==== tb/cpw_props.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Port checker for the PWM block
// ----------------------------------------------------------------
module cpw_props
	import cpw_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        carrier_toggle_out,
	input wire logic        phase1_positive_out,
	input wire logic        phase1_inverse_out,
	input wire logic        phase2_positive_out,
	input wire logic        phase2_inverse_out,
	input wire logic        phase3_positive_out,
	input wire logic        phase3_inverse_out,
	input wire logic        crest_irq
);
	logic [CTRL_W-1:0] ctl, ctl_q, ctl_qq, ctl_q3; // Snooped control and its history
	logic [2:0]        pon;                        // Positive legs at active level
	logic [2:0]        ion;                        // Inverse legs at active level
	logic              settled;                    // Control unchanged long enough
	logic              bad;                        // Unmapped address
	assign bad = (paddr > ADDR_HALF_BUF) || (paddr[1:0] != 2'h0);
	assign pon = {phase3_positive_out, phase2_positive_out, phase1_positive_out} ~^ {3{ctl[CTRL_POS_LEVEL]}};
	assign ion = {phase3_inverse_out, phase2_inverse_out, phase1_inverse_out} ~^ {3{ctl[CTRL_INV_LEVEL]}};
	// Four-deep history, since pins lag control by one cycle
	assign settled = (ctl == ctl_q) && (ctl_q == ctl_qq) && (ctl_qq == ctl_q3);
	// Shadow of the control register, written like the design's
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl    <= CTRL_RESET;
			ctl_q  <= CTRL_RESET;
			ctl_qq <= CTRL_RESET;
			ctl_q3 <= CTRL_RESET;
		end else begin
			if (psel && penable && pwrite && pready && paddr == ADDR_CTRL)
				ctl <= pwdata[CTRL_W-1:0];
			ctl_q  <= ctl;
			ctl_qq <= ctl_q;
			ctl_q3 <= ctl_qq;
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_access;
		psel && penable;
	endsequence
	sequence s_run_steady;
		settled && ctl[CTRL_START];
	endsequence
	a_ready_high: assert property (s_access |-> pready) else $error("pready low in access");
	a_err_unmapped: assert property (s_access ##0 bad |-> pslverr && prdata == 32'h0) else $error("no error");
	a_err_mapped: assert property (s_access ##0 !bad |-> !pslverr) else $error("spurious error");
	a_no_overlap: assert property (s_run_steady ##0 !ctl[CTRL_NO_DEAD] |-> (pon & ion) == 3'h0)
		else $error("legs overlap");
	a_no_dead_comp: assert property (s_run_steady ##0 ctl[CTRL_NO_DEAD] |-> pon == ~ion)
		else $error("legs not complementary");
	a_stop_off: assert property (settled && !ctl[CTRL_START] |-> pon == 3'h0 && ion == 3'h0)
		else $error("pins not off");
	a_irq_mask: assert property (!ctl[CTRL_IRQ_EN] |-> !crest_irq) else $error("irq not masked");
	a_toggle_hold: assert property (s_run_steady ##0 !ctl[CTRL_TOGGLE_EN] |-> $stable(carrier_toggle_out))
		else $error("toggle moved");
	a_toggle_start: assert property ($rose(ctl[CTRL_START]) |-> ##[1:3] carrier_toggle_out)
		else $error("toggle not high");
endmodule : cpw_props
bind cpw_top cpw_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
	.pslverr, .carrier_toggle_out, .phase1_positive_out, .phase1_inverse_out, .phase2_positive_out,
	.phase2_inverse_out, .phase3_positive_out, .phase3_inverse_out, .crest_irq);
`default_nettype wire

// ==== tb/cpw_gate_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Inverter gate drivers: count shoot-through
// ----------------------------------------------------------------
module cpw_gate_model (
	input  wire logic [2:0] pos,      // Positive gate inputs
	input  wire logic [2:0] inv,      // Inverse gate inputs
	input  wire logic       lvl,      // Active level of both legs
	input  wire logic       armed,    // Only judged while running steady
	input  wire logic       pclk,
	output int              shoot_cnt
);
	initial shoot_cnt = 0;
	// A leg pair both on shorts the bridge
	always @(posedge pclk) begin
		if (armed && ((pos ~^ {3{lvl}}) & (inv ~^ {3{lvl}})) != 3'h0)
			shoot_cnt++;
	end
endmodule : cpw_gate_model
`default_nettype wire

// ==== tb/three_phase_complementary_pwm_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module three_phase_complementary_pwm_bench;
	import cpw_pkg::*;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, tog, irq, err, lv = 1'b0, armed = 1'b0;
	wire  [2:0]  pp, pi; // Pin bits driven by separate output ports
	int          n_errors = 0, compares = 0, shoot, d, h, h2, du, nd, n, on;
	always #5 pclk = ~pclk;
	cpw_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.carrier_toggle_out(tog), .phase1_positive_out(pp[0]), .phase1_inverse_out(pi[0]),
		.phase2_positive_out(pp[1]), .phase2_inverse_out(pi[1]), .phase3_positive_out(pp[2]),
		.phase3_inverse_out(pi[2]), .crest_irq(irq));
	cpw_gate_model u_gate (.pos(pp), .inv(pi), .lvl(lv), .armed(armed), .pclk(pclk), .shoot_cnt(shoot));
	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic end_sim;
		if (n_errors == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_sim
	// 33 bits wide so the error flag beside a read word is compared too
	task automatic chk(input logic [32:0] got, input logic [32:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// One APB transfer; waits on pready, never on a fixed count
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the watchdog ends a wait that never sees pready
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	// Cycles to the next toggle edge, counting phase two on-time
	task automatic wtog(output int cyc);
		logic t0;
		cyc = 0;
		on = 0;
		t0 = tog;
		while (tog === t0 && cyc < 4000) begin
			@(posedge pclk);
			cyc++;
			if (pp[1] === 1'b0)
				on++;
		end
	endtask : wtog
	// Watchdog well beyond the expected few thousand cycles
	initial begin
		#300000;
		n_errors++;
		end_sim();
	end
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		void'($urandom(32'h7F342170));
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk({tog, pp, pi, irq}, 8'hFE);
		for (int a = 0; a <= 'h38; a += 4) begin
			apb(1'b0, 8'(a), 32'h0);
			// Status after reset: toggle level high, both counters marked as counting up
			chk({err, rd}, (a == ADDR_STATUS) ? 33'h1C : 33'h0);
		end
		apb(1'b0, 8'h3C, 32'h0);
		chk({err, rd}, 33'h100000000);
		apb(1'b0, 8'h06, 32'h0);
		chk({err, rd}, 33'h100000000);
		// Dead time, half cycle and its buffer: the last three mapped words
		for (int i = 0; i < 3; i++) begin
			n = $urandom;
			apb(1'b1, ADDR_DEAD + 8'(4 * i), 32'(n));
			apb(1'b0, ADDR_DEAD + 8'(4 * i), 32'h0);
			chk(rd, {16'h0, n[15:0]});
		end
		// Running set-up: active low, /4, toggle and interrupt on
		d = $urandom_range(6, 2);
		h = $urandom_range(40, 20);
		du = $urandom_range(h - 2, d + 2);
		apb(1'b1, ADDR_DEAD, 32'(d));
		apb(1'b1, ADDR_HALF, 32'(h));
		apb(1'b1, ADDR_UPPER_CMP, 32'(h + d));
		apb(1'b1, ADDR_PH1_CMP, 32'h0);
		apb(1'b1, ADDR_PH2_CMP, 32'(du));
		apb(1'b1, ADDR_PH3_CMP, 32'(h + d));
		apb(1'b1, ADDR_CTRL, 32'h65);
		wtog(n);
		armed <= 1'b1;
		wtog(n);
		chk(n, 8 * h);
		chk(on, 4 * (2 * (h - du) + 1));
		chk({pp[0], pi[0], pp[2], pi[2]}, 4'b0110);
		chk(irq, 1'b1);
		apb(1'b1, ADDR_STATUS, 32'h1);
		chk(irq, 1'b0);
		apb(1'b1, ADDR_CTRL, 32'h25);
		wtog(n);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk({irq, rd[STAT_CREST], rd[STAT_RUN]}, 3'b011);
		// Buffered update, refused direct write, phase three last
		h2 = $urandom_range(40, 20);
		nd = $urandom_range(h2 - 2, d + 2);
		apb(1'b1, ADDR_PH1_CMP, 32'h5);
		apb(1'b1, ADDR_PH1_BUF, 32'(nd));
		apb(1'b1, ADDR_HALF_BUF, 32'(h2));
		apb(1'b1, ADDR_UPPER_BUF, 32'(h2 + d));
		apb(1'b1, ADDR_PH2_BUF, 32'(du));
		apb(1'b1, ADDR_PH3_BUF, 32'(h2 + d));
		apb(1'b0, ADDR_PH1_CMP, 32'h0);
		chk(rd, 32'h0);
		wtog(n);
		wtog(n);
		wtog(n);
		chk(n, 8 * h2);
		apb(1'b0, ADDR_PH1_CMP, 32'h0);
		chk(rd, 32'(nd));
		apb(1'b0, ADDR_HALF, 32'h0);
		chk(rd, 32'(h2));
		// Stop, then no dead time with both legs active high
		armed <= 1'b0;
		apb(1'b1, ADDR_CTRL, 32'h0);
		repeat (3) @(posedge pclk);
		chk({pp, pi}, 6'h3F);
		apb(1'b1, ADDR_CTRL, 32'h1B);
		lv <= 1'b1;
		repeat (10) @(posedge pclk);
		armed <= 1'b1;
		chk({pp[2], pi[2]}, 2'b01);
		repeat (200) @(posedge pclk);
		chk(pp[1] ^ pi[1], 1'b1);
		chk(shoot, 0);
		end_sim();
	end
endmodule : three_phase_complementary_pwm_bench
`default_nettype wire
